/* File: core/sar_adc_scan_sequencer.v */
// Scan sequencer for a twelve-channel successive-approximation converter
// Functional notes
// - Each selected channel is converted and stored in its own result pair.
// - Result registers of unselected channels keep their previous value.
// - Run written with no channel selected stays zero; nothing starts.
// - Setting run starts converting selected channels, lowest number first.
// - Completion interrupt rises after highest selected channel finishes.
// - After last channel, loop bit picks stop or automatic restart.
// - Selection latched at scan start; changes ignored until completion.
// - Writing zero to run stops conversion; run resets to zero.
// - Loop clear and last channel done clears run automatically.
// - Each channel conversion is allowed about 43 microseconds.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "scan_seq_defines.vh"
module sar_adc_scan_sequencer #(
    parameter CONV_CYCLES = `CONV_CYCLES,
    parameter RES_W       = 10
) (
    input  wire             ref_clk,
    input  wire             sys_rst,
    input  wire [7:0]       s_axi_awaddr,
    input  wire             s_axi_awvalid,
    output reg              s_axi_awready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output reg              s_axi_wready,
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    input  wire [7:0]       s_axi_araddr,
    input  wire             s_axi_arvalid,
    output reg              s_axi_arready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready,
    input  wire [RES_W-1:0] conv_sample,
    output reg              conv_enable_q,
    output reg  [3:0]       conv_channel_q,
    output reg              conv_done_irq
);
    localparam ST_IDLE = 2'd0;
    localparam ST_PICK = 2'd1;
    localparam ST_CONV = 2'd2;
    localparam NCH     = 12;

    reg [1:0]       state_q;
    reg             conv_run_bit_q;
    reg             scan_loop_bit_q;
    reg [7:0]       chan_select_low_q;
    reg [3:0]       chan_select_high_q;
    reg [11:0]      scan_set_q;
    reg [11:0]      remaining_q;
    reg [0:0]       irq_status_q;
    reg [0:0]       irq_mask_q;
    reg [RES_W-1:0] result_q [0:NCH-1];
    reg [7:0]       aw_addr_q;
    reg [31:0]      w_data_q;
    reg [3:0]       w_strb_q;
    reg             aw_have_q;
    reg             w_have_q;
    reg             start_q;
    wire            timer_busy;
    wire            timer_done;
    wire [RES_W-1:0] timer_result;
    integer         i;

    // Lowest set bit of a channel mask, 4'hf when none
    function [3:0] lowest_chan;
        input [11:0] mask;
        integer k;
        begin
            lowest_chan = 4'hf;
            for (k = NCH - 1; k >= 0; k = k - 1)
                if (mask[k])
                    lowest_chan = k[3:0];
        end
    endfunction

    // Mask with one channel's bit taken out
    function [11:0] drop_chan;
        input [11:0] mask;
        input [3:0]  ch;
        begin
            drop_chan = mask & ~(12'h001 << ch);
        end
    endfunction

    // One aligned word per channel from the result base on
    function result_hit;
        input [7:0] addr;
        begin
            result_hit = (addr[7:6] == 2'b01) && (addr[5:2] < NCH);
        end
    endfunction

    wire [11:0] sel_now    = {chan_select_high_q, chan_select_low_q};
    // One write at a time: a new pair waits until the response is gone
    wire        wr_fire    = aw_have_q && w_have_q && !s_axi_bvalid;
    wire        wr_run     = wr_fire && (aw_addr_q == `OFF_CONTROL_ONE)
                             && w_strb_q[0];
    wire        last_done  = (state_q == ST_CONV) && timer_done
                             && (drop_chan(remaining_q, conv_channel_q)
                                 == 12'h0);
    // Stop works in any state, between channels too
    wire        stop_req   = wr_run && !w_data_q[`RUN_BIT];

    conv_timer #(
        .CYCLES (CONV_CYCLES),
        .RES_W  (RES_W)
    ) u_timer (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .start     (start_q),
        .abort     (stop_req),
        .sample_in (conv_sample),
        .busy_q    (timer_busy),
        .done_q    (timer_done),
        .result_q  (timer_result)
    );

    // Sequencer
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_q        <= ST_IDLE;
            conv_run_bit_q <= 1'b0;
            scan_set_q     <= 12'h0;
            remaining_q    <= 12'h0;
            conv_channel_q <= 4'h0;
            conv_enable_q  <= 1'b0;
            start_q        <= 1'b0;
            for (i = 0; i < NCH; i = i + 1)
                result_q[i] <= {RES_W{1'b0}};
        end
        else
        begin
            start_q <= 1'b0;
            case (state_q)
            ST_IDLE:
            begin
                // Enable falls a cycle after the last result is stored
                conv_enable_q <= 1'b0;
                if (wr_run && w_data_q[`RUN_BIT] && sel_now != 12'h0)
                begin
                    conv_run_bit_q <= 1'b1;
                    scan_set_q     <= sel_now;
                    remaining_q    <= sel_now;
                    state_q        <= ST_PICK;
                end
            end
            ST_PICK:
            begin
                conv_enable_q  <= 1'b1;
                conv_channel_q <= lowest_chan(remaining_q);
                start_q        <= 1'b1;
                state_q        <= ST_CONV;
            end
            ST_CONV:
            begin
                if (timer_done)
                begin
                    // one write of the whole pair
                    result_q[conv_channel_q] <= timer_result;
                    remaining_q <= drop_chan(remaining_q, conv_channel_q);
                    if (last_done)
                    begin
                        if (scan_loop_bit_q)
                        begin
                            // Empty selection reuses the old set
                            scan_set_q  <= sel_now;
                            remaining_q <= (sel_now != 12'h0) ?
                                           sel_now : scan_set_q;
                            if (sel_now == 12'h0)
                                scan_set_q <= scan_set_q;
                            state_q     <= ST_PICK;
                        end
                        else
                        begin
                            conv_run_bit_q <= 1'b0;
                            state_q        <= ST_IDLE;
                        end
                    end
                    else
                    begin
                        state_q <= ST_PICK;
                    end
                end
            end
            default:
                state_q <= ST_IDLE;
            endcase
            if (stop_req)
            begin
                conv_run_bit_q <= 1'b0;
                conv_enable_q  <= 1'b0;
                // Drop a pending start, else a stale done hits the next scan
                start_q        <= 1'b0;
                state_q        <= ST_IDLE;
            end
        end
    end

    // Register bus, write side; aw and w taken in either order
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s_axi_awready      <= 1'b0;
            s_axi_wready       <= 1'b0;
            s_axi_bvalid       <= 1'b0;
            s_axi_bresp        <= `RESP_OKAY;
            aw_have_q          <= 1'b0;
            w_have_q           <= 1'b0;
            aw_addr_q          <= 8'h0;
            w_data_q           <= 32'h0;
            w_strb_q           <= 4'h0;
            scan_loop_bit_q    <= 1'b0;
            chan_select_low_q  <= `RST_BYTE;
            chan_select_high_q <= 4'h0;
            irq_status_q       <= 1'b0;
            irq_mask_q         <= 1'b0;
            conv_done_irq      <= 1'b0;
        end
        else
        begin
            // Ready is a one-cycle pulse, so a held valid is taken once
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_fire)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (aw_addr_q)
                `OFF_CONTROL_ONE: ;
                `OFF_CONTROL_ZERO:
                    if (w_strb_q[0])
                        scan_loop_bit_q <= w_data_q[`LOOP_BIT];
                `OFF_SEL_LOW:
                    if (w_strb_q[0])
                        chan_select_low_q <= w_data_q[7:0];
                `OFF_SEL_HIGH:
                    if (w_strb_q[0])
                        chan_select_high_q <= w_data_q[3:0];
                `OFF_IRQ_MASK:
                    if (w_strb_q[0])
                        irq_mask_q <= w_data_q[0];
                `OFF_IRQ_STATUS: ;
                `OFF_SCAN_STATUS: ;
                default:
                    // Same window as reads, so a write past the last pair errors
                    if (!result_hit(aw_addr_q))
                        s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            if (last_done)
                irq_status_q <= 1'b1;
            else if (wr_fire && aw_addr_q == `OFF_IRQ_STATUS
                     && w_strb_q[0] && w_data_q[`IRQ_DONE_BIT])
                irq_status_q <= 1'b0;
            // Set in flight is or-ed in so the line rises with the status bit
            conv_done_irq <= (irq_status_q & irq_mask_q)
                             || (last_done && irq_mask_q);
        end
    end

    // Register bus, read side
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready
                             && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                s_axi_rdata  <= 32'h0;
                case (s_axi_araddr)
                `OFF_CONTROL_ONE:
                    s_axi_rdata <= {31'h0, conv_run_bit_q};
                `OFF_CONTROL_ZERO:
                    s_axi_rdata <= {31'h0, scan_loop_bit_q};
                `OFF_SEL_LOW:
                    s_axi_rdata <= {24'h0, chan_select_low_q};
                `OFF_SEL_HIGH:
                    s_axi_rdata <= {28'h0, chan_select_high_q};
                `OFF_IRQ_STATUS:
                    s_axi_rdata <= {31'h0, irq_status_q};
                `OFF_IRQ_MASK:
                    s_axi_rdata <= {31'h0, irq_mask_q};
                // Busy, latched set and current channel
                `OFF_SCAN_STATUS:
                    s_axi_rdata <= {15'h0, timer_busy, scan_set_q,
                                    conv_channel_q};
                default:
                    if (result_hit(s_axi_araddr))
                        // Pair read as one word, so halves never mix
                        s_axi_rdata <= {{(32-RES_W){1'b0}},
                                        result_q[s_axi_araddr[5:2]]};
                    else
                        s_axi_rresp <= `RESP_SLVERR;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: core/scan_seq_defines.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef SCAN_SEQ_DEFINES_VH
`define SCAN_SEQ_DEFINES_VH

`define OFF_CONTROL_ONE   8'h00
`define OFF_CONTROL_ZERO  8'h04
`define OFF_SEL_LOW       8'h08
`define OFF_SEL_HIGH      8'h0c
`define OFF_IRQ_STATUS    8'h10
`define OFF_IRQ_MASK      8'h14
`define OFF_SCAN_STATUS   8'h18
`define OFF_RESULT_BASE   8'h40

`define RUN_BIT           0
`define LOOP_BIT          0
`define SEL_LOW_W         8
`define SEL_HIGH_W        4
`define IRQ_DONE_BIT      0

`define RST_BYTE          8'h00
`define CONV_TIME_NS      43000
`define CLK_PERIOD_NS     10
`define CONV_CYCLES       ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

/* File: core/conv_timer.v */
// Per-channel conversion timer with result capture
`timescale 1ns/1ps
`default_nettype none
module conv_timer #(
    parameter CYCLES = 4300,
    parameter RES_W  = 10
) (
    input  wire             ref_clk,
    input  wire             sys_rst,
    input  wire             start,
    input  wire             abort,
    input  wire [RES_W-1:0] sample_in,
    output reg              busy_q,
    output reg              done_q,
    output reg  [RES_W-1:0] result_q
);
    reg [31:0] count_q;

    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            count_q  <= 32'h0;
            result_q <= {RES_W{1'b0}};
        end
        else
        begin
            done_q <= 1'b0;
            if (abort)
            begin
                busy_q <= 1'b0;
            end
            else if (start)
            begin
                busy_q  <= 1'b1;
                count_q <= CYCLES - 1;
            end
            else if (busy_q)
            begin
                if (count_q == 32'h0)
                begin
                    busy_q   <= 1'b0;
                    done_q   <= 1'b1;
                    result_q <= sample_in;
                end
                else
                begin
                    count_q <= count_q - 32'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/adc_core_model.sv */
// Behavioural converter core returning channel-tagged samples
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    input  wire logic       ref_clk,
    input  wire logic       conv_enable_q,
    input  wire logic [3:0] conv_channel_q,
    input  wire logic [5:0] salt,
    output var  logic [9:0] conv_sample
);
    initial conv_sample = 10'h2aa;
    // Idle output toggles so a stale sample never passes for data
    always @(posedge ref_clk)
        conv_sample <= conv_enable_q ? {conv_channel_q, salt} : ~conv_sample;
endmodule
`default_nettype wire

/* File: verification/scan_seq_props.sv */
// Port-level checks for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module scan_seq_props #(
    parameter CONV_CYCLES = 20
) (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        conv_enable_q,
    input wire logic [3:0]  conv_channel_q,
    input wire logic        conv_done_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] dwell_q;
    logic [3:0]  ch_q;
    // Cycles the current channel has been held while converting
    always @(posedge ref_clk)
    begin
        ch_q <= conv_channel_q;
        if (sys_rst || !conv_enable_q || conv_channel_q != ch_q)
            dwell_q <= 16'h0;
        else
            dwell_q <= dwell_q + 16'h1;
    end
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence chan_step;
        conv_enable_q && $past(conv_enable_q)
            && conv_channel_q != $past(conv_channel_q);
    endsequence
    a_reset_quiet: assert property (disable iff (1'h0)
        sys_rst ##1 sys_rst |-> !conv_enable_q && !conv_done_irq
            && !s_axi_bvalid && !s_axi_rvalid) else $error("busy in reset");
    a_chan_range: assert property (conv_enable_q
        |-> conv_channel_q <= 4'hb) else $error("channel out of range");
    a_chan_dwell: assert property (chan_step
        |-> dwell_q >= CONV_CYCLES - 1) else $error("channel time short");
    a_write_answer: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    a_read_answer: assert property (ar_taken |-> ##1 s_axi_rvalid)
        else $error("read response not on time");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
endmodule
bind sar_adc_scan_sequencer scan_seq_props #(.CONV_CYCLES(CONV_CYCLES))
    i_scan_seq_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .conv_enable_q(conv_enable_q), .conv_channel_q(conv_channel_q),
    .conv_done_irq(conv_done_irq));
`default_nettype wire

/* File: verification/sar_adc_scan_sequencer_tb.sv */
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
`include "scan_seq_defines.vh"
module sar_adc_scan_sequencer_tb;
    logic        ref_clk = 1'h0;
    logic        sys_rst = 1'h1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0, en_q = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, en, irq;
    logic [1:0]  bresp, rresp;
    logic [3:0]  chan, ch_q = 4'h0;
    logic [5:0]  salt = 6'h00;
    logic [9:0]  sample;
    logic [9:0]  res [12];
    logic [11:0] sel_a;
    logic [41:0] rq [$];
    logic [3:0]  cq [$];
    logic [1:0]  bq [$];
    int          error_cnt = 0, checks_done = 0;

    sar_adc_scan_sequencer #(.CONV_CYCLES(20)) i_sar_adc_scan_sequencer (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .conv_sample(sample),
        .conv_enable_q(en), .conv_channel_q(chan), .conv_done_irq(irq));
    adc_core_model i_adc_core_model (.ref_clk(ref_clk),
        .conv_enable_q(en), .conv_channel_q(chan), .salt(salt),
        .conv_sample(sample));

    initial
        forever #5 ref_clk = ~ref_clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk_word(input string n, input logic [33:0] e,
                            input logic [33:0] s);
        // Error replies carry no defined data
        if (e[33:32] == `RESP_SLVERR)
            s[31:0] = e[31:0];
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask

    task automatic chk_chan(input logic [3:0] e, input logic [3:0] s);
        checks_done++;
        if (s !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED channel exp %h got %h", e, s);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r = `RESP_OKAY);
        @(posedge ref_clk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge ref_clk);
        rq.push_back({a, e});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
    endtask

    task automatic do_scan(input logic [11:0] sel, input int passes);
        logic [5:0] s;
        s = 6'($urandom);
        salt <= s;
        for (int p = 0; p < passes; p++)
            for (int c = 0; c < 12; c++)
                if (sel[c]) cq.push_back(4'(c));
        for (int c = 0; c < 12; c++)
            if (sel[c]) res[c] = {4'(c), s};
        axi_wr(`OFF_SEL_LOW, {24'h0, sel[7:0]});
        axi_wr(`OFF_SEL_HIGH, {28'h0, sel[11:8]});
        axi_wr(`OFF_CONTROL_ONE, 32'h1);
        if (passes == 1) axi_wr(`OFF_SEL_LOW, {24'h0, ~sel[7:0]});
    endtask

    task automatic irq_is(input logic v);
        repeat (3) @(posedge ref_clk);
        chk_word("irq", {33'h0, v}, {33'h0, irq});
    endtask

    // Results appear at the read or write handshake or at a new channel
    always @(posedge ref_clk)
    begin
        if (rvalid && rready)
            chk_word($sformatf("reg %h", rq[0][41:34]),
                     rq[0][33:0], {rresp, rdata});
        if (rvalid && rready)
            void'(rq.pop_front());
        if (bvalid && bready)
            chk_word("bresp", {bq.pop_front(), 32'h0}, {bresp, 32'h0});
        if (en && (!en_q || chan != ch_q))
            chk_chan(cq.pop_front(), chan);
        en_q <= en;
        ch_q <= chan;
    end

    initial
    begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        finish_test();
    end

    initial
    begin
        void'($urandom(32'hb1e24233));
        for (int c = 0; c < 12; c++) res[c] = 10'h0;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'h0;
        for (int a = 0; a < 'h1c; a += 4)
            axi_rd(8'(a), 34'h0);
        axi_rd(8'h3c, {`RESP_SLVERR, 32'h0});
        axi_wr(8'h3c, 32'h1, `RESP_SLVERR);
        $display("test reset values done");
        axi_wr(`OFF_CONTROL_ONE, 32'h1);
        axi_rd(`OFF_CONTROL_ONE, 34'h0);
        $display("test empty selection done");
        axi_wr(`OFF_IRQ_MASK, 32'h1);
        sel_a = 12'($urandom) | 12'h800;
        do_scan(sel_a, 1);
        wait (irq === 1'h1);
        axi_rd(`OFF_CONTROL_ONE, 34'h0);
        axi_rd(`OFF_IRQ_STATUS, 34'h1);
        axi_wr(`OFF_IRQ_STATUS, 32'h1);
        irq_is(1'h0);
        do_scan((12'($urandom) & ~sel_a) | 12'h001, 1);
        wait (irq === 1'h1);
        axi_wr(`OFF_IRQ_MASK, 32'h0);
        irq_is(1'h0);
        axi_wr(`OFF_IRQ_MASK, 32'h1);
        irq_is(1'h1);
        axi_wr(`OFF_IRQ_STATUS, 32'h1);
        irq_is(1'h0);
        for (int c = 0; c < 12; c++)
            axi_rd(8'(`OFF_RESULT_BASE + 4 * c), {24'h0, res[c]});
        $display("test single scans done");
        axi_wr(`OFF_CONTROL_ZERO, 32'h1);
        do_scan(12'h801, 3);
        repeat (2)
        begin
            wait (irq === 1'h1);
            axi_wr(`OFF_IRQ_STATUS, 32'h1);
            irq_is(1'h0);
        end
        axi_wr(`OFF_CONTROL_ZERO, 32'h0);
        wait (irq === 1'h1);
        axi_wr(`OFF_IRQ_STATUS, 32'h1);
        axi_rd(`OFF_CONTROL_ONE, 34'h0);
        $display("test loop done");
        do_scan(12'h0ff, 1);
        repeat (30) @(posedge ref_clk);
        axi_wr(`OFF_CONTROL_ONE, 32'h0);
        irq_is(1'h0);
        cq.delete();
        chk_word("enable", 34'h0, {33'h0, en});
        axi_rd(`OFF_CONTROL_ONE, 34'h0);
        repeat (100) @(posedge ref_clk);
        $display("test stop done");
        finish_test();
    end
endmodule
`default_nettype wire
